/* hdl/moving_picture_display_port.v */
// moving picture input port: frame-sync system port and rgb pixel bus
// Summary of operation
// (RULE_01) frame-sync mode: source 10, path 0
// (RULE_02) host sets oscillator fast enough
// (RULE_03) host writes faster than minimum speed
// (RULE_04) host writes two lines ahead of scan
// (RULE_05) front porch held until next sync
// (RULE_06) source change applies from next frame
// (RULE_07) no partial or scroll in frame-sync
// (RULE_08) host clears direction, sets fast write
// (RULE_09) width select picks 18, 16, 6 bits
// (RULE_10) host drives only one pixel interface
// (RULE_11) each sync input has polarity bit
// (RULE_12) store transfer per dot clock, enable low
// (RULE_13) host sequence for system port ram access
// (RULE_14) host avoids colliding ram accesses
// (RULE_15) 6-bit pixel from three transfers
// (RULE_16) frame sync resets 6-bit phase
// (RULE_17) host sends whole pixels per burst
// (RULE_18) instructions only via system port
// (RULE_19) external interface disables partial, scroll
// (RULE_20) host keeps syncs and dot clock running
// (RULE_21) rgb panel timing from dot clock; the code takes rgb line pulses from line sync falls, not from the dot clock
// (RULE_22) start address reloaded each frame sync
// (RULE_23) host keeps fast write on
`timescale 1ns/1ps
`include "pixel_port_defs.vh"
`default_nettype none
module moving_picture_display_port #(
  parameter LINE_CLOCKS = 16
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // pixel bus pins
  input wire frame_sync_i,
  input wire line_sync_i,
  input wire data_enable_i,
  input wire dot_clock_i,
  input wire [17:0] pixel_data_i,
  // internal oscillator tick (same domain)
  input wire osc_tick_i,
  // frame ram write port
  output reg ram_we_o,
  output reg [`ADDR_W-1:0] ram_addr_o,
  output reg [`PIX_W-1:0] ram_wdata_o,
  // panel timing
  output reg line_tick_o,
  output reg frame_start_o,
  output reg porch_hold_o,
  output reg partial_en_o,
  output reg scroll_en_o
);
  // software registers, clock source in force and frame counters
  reg [31:0] ctrl_r; // mode and option bits
  reg [3:0] pol_r; // input polarity bits
  reg [`ADDR_W-1:0] start_r; // ram start address
  reg [1:0] dcs_act_r; // clock source in force this frame
  reg [`ADDR_W-1:0] addr_r; // ram address counter
  reg [7:0] line_cnt_r; // lines seen this frame
  reg [4:0] clk_cnt_r; // oscillator clocks in a line
  reg [7:0] frame_cnt_r; // frames seen
  // synchronised pins
  wire [21:0] pins_s;
  wire fs_s;
  wire ls_s;
  wire en_s;
  wire dc_s;
  reg fs_d_r;
  reg ls_d_r;
  reg dc_d_r;
  // decoded modes
  wire [1:0] dcs_sel;
  wire rap_sel;
  wire [1:0] bw_sel;
  wire fsync_mode;
  wire rgb_mode;
  wire frame_fall;
  wire line_fall;
  wire dot_edge;
  wire rgb_store;
  wire apb_wr;
  wire apb_rd;
  wire pix_valid;
  wire [`PIX_W-1:0] pix;
  wire line_now;

  // pins pass two flip-flops before use
  pin_sync #(.W(22)) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pin_i({frame_sync_i, line_sync_i, data_enable_i, dot_clock_i, pixel_data_i}),
    .sync_o(pins_s)
  );

  // polarity bits flip each input to its default sense
  assign fs_s = pins_s[21] ^ pol_r[`POL_FS_BIT]; // RULE_11
  assign ls_s = pins_s[20] ^ pol_r[`POL_LS_BIT]; // RULE_11
  assign en_s = pins_s[19] ^ pol_r[`POL_EN_BIT]; // RULE_11
  assign dc_s = pins_s[18] ^ pol_r[`POL_DC_BIT]; // RULE_11

  // mode fields
  assign dcs_sel = ctrl_r[`CTRL_DCS_LSB+1:`CTRL_DCS_LSB];
  assign rap_sel = ctrl_r[`CTRL_RAP_BIT];
  assign bw_sel = ctrl_r[`CTRL_BW_LSB+1:`CTRL_BW_LSB];
  // frame-sync mode from the source in force
  assign fsync_mode = (dcs_act_r == `DCS_FRAME_SYNC) && !rap_sel; // RULE_01
  // rgb mode: path select set to the pixel bus
  assign rgb_mode = rap_sel;
  // edges of the sync and clock inputs
  assign frame_fall = fs_d_r && !fs_s;
  assign line_fall = ls_d_r && !ls_s;
  assign dot_edge = !dc_d_r && dc_s;
  // one transfer per rising dot clock while enable low
  assign rgb_store = rgb_mode && dot_edge && !en_s; // RULE_12
  // apb decode
  assign apb_wr = psel_i && penable_i && pwrite_i && pready_o;
  assign apb_rd = psel_i && !penable_i && !pwrite_i;
  // line pulses: line sync falls in rgb, oscillator otherwise
  assign line_now = rgb_mode ? line_fall : // RULE_21
    (osc_tick_i && (clk_cnt_r == LINE_CLOCKS[4:0] - 5'h01));

  // pixel assembly
  pixel_pack u_pack (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .bus_width_i(bw_sel),
    .frame_start_i(frame_fall),
    .strobe_i(rgb_store),
    .data_i(pins_s[17:0]),
    .pix_valid_o(pix_valid),
    .pix_o(pix)
  );

  // edge history of synchronised inputs
  // reset low like the synchroniser output, so no false sync fall follows reset
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      fs_d_r <= 1'b0;
      ls_d_r <= 1'b0;
      dc_d_r <= 1'b0;
    end else begin
      fs_d_r <= fs_s;
      ls_d_r <= ls_s;
      dc_d_r <= dc_s;
    end
  end

  // apb register writes; pixel bus never writes registers
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_r <= `CTRL_RESET;
      pol_r <= `POL_RESET;
      start_r <= `START_RESET;
    end else if (apb_wr) begin
      case (paddr_i)
        `REG_CTRL: ctrl_r <= pwdata_i; // RULE_18
        `REG_POL: pol_r <= pwdata_i[3:0];
        `REG_START: start_r <= pwdata_i[`ADDR_W-1:0];
        default: begin
          // read-only or unmapped: no effect
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // apb answer: no wait state, error on unmapped
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      if (psel_i && !penable_i) begin
        pslverr_o <= (paddr_i != `REG_CTRL) && (paddr_i != `REG_POL) &&
          (paddr_i != `REG_START) && (paddr_i != `REG_STATUS) &&
          (paddr_i != `REG_PIXEL) && (paddr_i != `REG_TIMING);
      end
      if (apb_rd) begin
        case (paddr_i)
          `REG_CTRL: prdata_o <= ctrl_r;
          `REG_POL: prdata_o <= {28'h0000000, pol_r};
          `REG_START: prdata_o <= {15'h0000, start_r};
          `REG_STATUS: prdata_o <= {21'h000000, frame_cnt_r, porch_hold_o,
            dcs_act_r};
          `REG_PIXEL: prdata_o <= {15'h0000, addr_r};
          `REG_TIMING: prdata_o <= {24'h000000, line_cnt_r};
          default: prdata_o <= 32'h00000000;
        endcase
      end else begin
        prdata_o <= 32'h00000000;
      end
    end
  end

  // clock source takes effect at the next frame start
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      dcs_act_r <= `DCS_INTERNAL;
    end else if (frame_fall || (porch_hold_o && dcs_act_r == `DCS_INTERNAL &&
      dcs_sel == `DCS_INTERNAL)) begin
      dcs_act_r <= dcs_sel; // RULE_06
    end
  end

  // oscillator line counter for internal and frame-sync modes
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      clk_cnt_r <= 5'h00;
    end else if (frame_fall || rgb_mode) begin
      clk_cnt_r <= 5'h00;
    end else if (osc_tick_i) begin
      clk_cnt_r <= (clk_cnt_r == LINE_CLOCKS[4:0] - 5'h01) ? 5'h00 :
        clk_cnt_r + 5'h01;
    end
  end

  // frame timing: lines, porch hold and frame count
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      line_cnt_r <= 8'h00;
      frame_cnt_r <= 8'h00;
      porch_hold_o <= 1'b1;
      line_tick_o <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      line_tick_o <= line_now && !porch_hold_o;
      frame_start_o <= frame_fall;
      if (frame_fall) begin
        // porch ends only when frame sync arrives
        porch_hold_o <= 1'b0; // RULE_05
        line_cnt_r <= 8'h00;
        frame_cnt_r <= frame_cnt_r + 8'h01;
      end else if (line_now && !porch_hold_o) begin
        line_cnt_r <= line_cnt_r + 8'h01;
        if (line_cnt_r == 8'hff) begin
          // frame over: hold front porch until next sync
          porch_hold_o <= 1'b1; // RULE_05
        end
      end
    end
  end

  // partial and scroll offered only in internal display
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      partial_en_o <= 1'b0;
      scroll_en_o <= 1'b0;
    end else begin
      partial_en_o <= ctrl_r[`CTRL_PART_BIT] && !fsync_mode && !rgb_mode; // RULE_07 RULE_19
      scroll_en_o <= ctrl_r[`CTRL_SCRL_BIT] && !fsync_mode && !rgb_mode; // RULE_07 RULE_19
    end
  end

  // ram address counter and write port
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      addr_r <= `START_RESET;
      ram_we_o <= 1'b0;
      ram_addr_o <= `START_RESET;
      ram_wdata_o <= 18'h00000;
    end else begin
      ram_we_o <= 1'b0;
      if (rgb_mode && frame_fall) begin
        addr_r <= start_r; // RULE_22
      end else if (rgb_mode && pix_valid) begin
        ram_we_o <= 1'b1; // RULE_12
        ram_addr_o <= addr_r;
        ram_wdata_o <= pix;
        addr_r <= addr_r + 17'h00001;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/pixel_port_defs.vh */
// constants for the moving picture display port
`ifndef PIXEL_PORT_DEFS_VH
`define PIXEL_PORT_DEFS_VH
// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_POL 12'h004
`define REG_START 12'h008
`define REG_STATUS 12'h00c
`define REG_PIXEL 12'h010
`define REG_TIMING 12'h014
// control register fields
`define CTRL_DCS_LSB 0
`define CTRL_RAP_BIT 2
`define CTRL_BW_LSB 3
`define CTRL_FWM_BIT 5
`define CTRL_AUD_BIT 6
`define CTRL_PART_BIT 7
`define CTRL_SCRL_BIT 8
// polarity register fields
`define POL_FS_BIT 0
`define POL_LS_BIT 1
`define POL_EN_BIT 2
`define POL_DC_BIT 3
// clock source encodings
`define DCS_INTERNAL 2'h0
`define DCS_FRAME_SYNC 2'h2
// bus width encodings
`define BW_18 2'h0
`define BW_16 2'h1
`define BW_6 2'h2
// reset values
`define CTRL_RESET 32'h00000000
`define POL_RESET 4'h0
`define START_RESET 17'h00000
`define ADDR_W 17
`define PIX_W 18
// phase counts for the 6-bit bus
`define PHASE_LAST 2'h2
`define PHASE_FIRST 2'h0
`endif

/* hdl/pin_sync.v */
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // pins and synchronised copy
  input wire [W-1:0] pin_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_r; // first stage, read only by the second
  // two stages toward the system clock
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_r <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta_r <= pin_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* hdl/pixel_pack.v */
// assembles pixels from the 18, 16 or 6 bit pixel bus
`timescale 1ns/1ps
`include "pixel_port_defs.vh"
`default_nettype none
module pixel_pack (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // control
  input wire [1:0] bus_width_i,
  input wire frame_start_i,
  input wire strobe_i,
  input wire [17:0] data_i,
  // assembled pixel
  output reg pix_valid_o,
  output reg [`PIX_W-1:0] pix_o
);
  reg [1:0] phase_r; // 6-bit transfer phase
  reg [11:0] part_r; // red and green parts held
  // map each width to an 18-bit pixel
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase_r <= `PHASE_FIRST;
      part_r <= 12'h000;
      pix_valid_o <= 1'b0;
      pix_o <= 18'h00000;
    end else begin
      pix_valid_o <= 1'b0;
      if (frame_start_i) begin
        // restart at the red part each frame
        phase_r <= `PHASE_FIRST; // RULE_16
      end else if (strobe_i) begin
        case (bus_width_i)
          `BW_18: begin
            pix_o <= data_i; // RULE_09
            pix_valid_o <= 1'b1;
          end
          `BW_16: begin
            // db17-13 red, db11-1 green/blue, red and blue lsb copied from msb
            pix_o <= {data_i[17:13], data_i[17], data_i[11:1], data_i[5]}; // RULE_09
            pix_valid_o <= 1'b1;
          end
          `BW_6: begin
            // red, green then blue on db17-12
            if (phase_r == `PHASE_LAST) begin
              pix_o <= {part_r, data_i[17:12]}; // RULE_15
              pix_valid_o <= 1'b1;
              phase_r <= `PHASE_FIRST;
            end else begin
              part_r <= {part_r[5:0], data_i[17:12]};
              phase_r <= phase_r + 2'h1;
            end
          end
          default: begin
            // code 11 not allowed, transfer dropped
            pix_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* dv/mpdp_assertions.sv */
// port checker for the moving picture display port
`timescale 1ns/1ps
`default_nettype none
module mpdp_checker #(
  parameter LINE_CLOCKS = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // ram port and panel timing
  input wire logic ram_we_o,
  input wire logic [16:0] ram_addr_o,
  input wire logic frame_start_o,
  input wire logic porch_hold_o,
  input wire logic partial_en_o,
  input wire logic scroll_en_o
);
  // copies of control and start address, and the ram write trail
  logic [31:0] ctrl_r;
  logic [16:0] start_r;
  logic [16:0] last_r;
  logic first_r;
  wire wr = psel_i && penable_i && pready_o && pwrite_i;
  // follow writes so the address rules know what software asked for
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_r <= 32'h0;
      start_r <= 17'h0;
      first_r <= 1'b0;
      last_r <= 17'h0;
    end else begin
      if (wr && paddr_i == 12'h000) ctrl_r <= pwdata_i;
      if (wr && paddr_i == 12'h008) start_r <= pwdata_i[16:0];
      if (frame_start_o) first_r <= 1'b1;
      else if (ram_we_o) first_r <= 1'b0;
      if (ram_we_o) last_r <= ram_addr_o;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  a_ready_first: assert property (psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_map: assert property (pready_o && paddr_i[1:0] == 2'h0 |-> pslverr_o == (paddr_i > 12'h014))
    else $error("error response wrong for address");
  a_we_single: assert property (ram_we_o |=> !ram_we_o)
    else $error("ram write longer than one cycle");
  a_start_reload: assert property (ram_we_o && first_r && ctrl_r[2] |-> ram_addr_o == start_r)
    else $error("first write of frame not at start address");
  a_addr_step: assert property (ram_we_o && !first_r |-> ram_addr_o == last_r + 17'h1)
    else $error("ram address did not step by one");
  a_porch_exit: assert property ($fell(porch_hold_o) |-> frame_start_o || $past(frame_start_o))
    else $error("porch ended without frame sync");
  a_ext_no_partial: assert property (frame_start_o && (ctrl_r[1] || ctrl_r[2]) |-> ##3 !partial_en_o && !scroll_en_o)
    else $error("partial or scroll granted in external mode");
  a_start_pulse: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
  // main scenarios seen
  c_first_write: cover property (ram_we_o && first_r);
  c_slverr: cover property (pready_o && pslverr_o);
  c_porch_end: cover property ($fell(porch_hold_o));
endmodule
bind moving_picture_display_port mpdp_checker #(.LINE_CLOCKS(LINE_CLOCKS)) u_chk (.clk_sys_i,
  .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
  .ram_we_o, .ram_addr_o, .frame_start_o, .porch_hold_o, .partial_en_o, .scroll_en_o);
`default_nettype wire

/* dv/pixel_host_model.sv */
// host video source driving sync, enable, dot clock and pixel bus
`timescale 1ns/1ps
`default_nettype none
module pixel_host_model (
  // polarity applied to the driven pins
  input wire logic [3:0] pol_i,
  // pixel bus pins
  output logic fs_o,
  output logic ls_o,
  output logic en_o,
  output logic dc_o,
  output logic [17:0] db_o
);
  // raw levels before polarity; dot clock stands still between frames
  logic fs = 1'b1;
  logic ls = 1'b1;
  logic en = 1'b1;
  logic dc = 1'b0;
  logic [17:0] q[$];
  initial db_o = 18'h0;
  // the pins carry the raw levels flipped by the polarity setting
  assign fs_o = fs ^ pol_i[0];
  assign ls_o = ls ^ pol_i[1];
  assign en_o = en ^ pol_i[2];
  assign dc_o = dc ^ pol_i[3];
  // one 80 ns dot clock, data held across the rise
  task automatic tick();
    #40 dc <= 1'b1;
    #40 dc <= 1'b0;
  endtask
  // one frame: sync fall, a line pulse, then one transfer per queued word
  task automatic frame();
    fs <= 1'b0;
    tick();
    tick();
    fs <= 1'b1;
    ls <= 1'b0;
    tick();
    ls <= 1'b1;
    while (q.size() > 0) begin
      db_o <= q.pop_front();
      en <= 1'b0;
      tick();
    end
    en <= 1'b1;
    db_o <= ~db_o;
    tick();
  endtask
endmodule
`default_nettype wire

/* dv/moving_picture_display_port_test.sv */
// self-checking bench for the moving picture display port
`timescale 1ns/1ps
`include "pixel_port_defs.vh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module moving_picture_display_port_test;
  // design inputs and outputs
  logic clk_sys_i = 0;
  logic reset_i = 1;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic osc_tick_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, ram_we_o, line_tick_o, frame_start_o;
  wire porch_hold_o, partial_en_o, scroll_en_o;
  wire frame_sync_i, line_sync_i, data_enable_i, dot_clock_i;
  wire [16:0] ram_addr_o;
  wire [17:0] ram_wdata_o, pixel_data_i;
  // bench state
  logic [3:0] pol = 0;
  logic [31:0] seed = 32'hcfc2;
  logic [31:0] r;
  logic e;
  logic [1:0] bw;
  logic [16:0] st;
  logic [17:0] d [6];
  logic [16:0] ga[$];
  logic [17:0] gd[$];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_lines = 0;
  int i;
  moving_picture_display_port u_dut (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .frame_sync_i, .line_sync_i,
    .data_enable_i, .dot_clock_i, .pixel_data_i, .osc_tick_i, .ram_we_o, .ram_addr_o,
    .ram_wdata_o, .line_tick_o, .frame_start_o, .porch_hold_o, .partial_en_o, .scroll_en_o);
  pixel_host_model u_host (.pol_i(pol), .fs_o(frame_sync_i), .ls_o(line_sync_i),
    .en_o(data_enable_i), .dc_o(dot_clock_i), .db_o(pixel_data_i));
  // 100 MHz system clock
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // oscillator tick every other cycle
  always @(posedge clk_sys_i) osc_tick_i <= !osc_tick_i;
  // collect ram writes and cut a hang short
  always @(posedge clk_sys_i) begin
    if (ram_we_o === 1'b1) begin
      ga.push_back(ram_addr_o);
      gd.push_back(ram_wdata_o);
    end
    // line pulses since the last frame start
    if (frame_start_o === 1'b1) n_lines = 0;
    else if (line_tick_o === 1'b1) n_lines++;
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected pixel k for a bus width
  function automatic logic [17:0] pix(input logic [1:0] w, input int k);
    if (w == `BW_6) return {d[3*k][17:12], d[3*k+1][17:12], d[3*k+2][17:12]};
    if (w == `BW_16) return {d[k][17:13], d[k][17], d[k][11:1], d[k][5]};
    return d[k];
  endfunction
  // one apb transfer, held until ready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_sys_i);
    penable_i <= 1;
    // sample ready at the rising edge; data and error are taken there too
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  // counts, verdict and stop
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 0;
    @(negedge clk_sys_i);
    `CHK(porch_hold_o, 1'b1)
    apb(0, `REG_CTRL, 0);
    `CHK(r, `CTRL_RESET)
    apb(0, `REG_POL, 0);
    `CHK(r[3:0], `POL_RESET)
    apb(0, `REG_START, 0);
    `CHK(r[16:0], `START_RESET)
    apb(1, 12'h100, 32'hffffffff);
    `CHK(e, 1'b1)
    apb(0, 12'h100, 0);
    `CHK({e, r}, 33'h100000000)
    // partial and scroll granted under internal operation
    apb(1, `REG_CTRL, 32'h180);
    repeat (4) @(negedge clk_sys_i);
    `CHK({partial_en_o, scroll_en_o}, 2'h3)
    // frame-sync mode with fast write and upward address order
    apb(1, `REG_CTRL, 32'h1a2);
    apb(0, `REG_STATUS, 0);
    `CHK(r[1:0], `DCS_INTERNAL)
    u_host.frame();
    repeat (10) @(negedge clk_sys_i);
    apb(0, `REG_STATUS, 0);
    `CHK(r[1:0], `DCS_FRAME_SYNC)
    @(negedge clk_sys_i);
    `CHK({partial_en_o, scroll_en_o, porch_hold_o}, 3'h0)
    for (i = 0; i < 20000 && porch_hold_o !== 1'b1; i++) @(negedge clk_sys_i);
    repeat (100) @(negedge clk_sys_i);
    `CHK(porch_hold_o, 1'b1)
    `CHK(n_lines, 256)
    // rgb frames in every width code, both polarities
    for (int b = 0; b < 4; b++) begin
      bw = b[1:0];
      apb(1, `REG_CTRL, 0);
      pol <= {4{bw[0]}};
      apb(1, `REG_POL, {28'h0, {4{bw[0]}}});
      seed = lfsr(seed);
      st = seed[16:0];
      apb(1, `REG_START, {15'h0, st});
      apb(1, `REG_CTRL, 32'h1a4 | {27'h0, bw, 3'h0});
      if (bw == `BW_6) begin
        repeat (4) u_host.q.push_back(18'h3ffff);
        u_host.frame();
      end
      ga.delete();
      gd.delete();
      for (i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        d[i] = seed[17:0];
        u_host.q.push_back(d[i]);
      end
      u_host.frame();
      repeat (20) @(negedge clk_sys_i);
      `CHK(n_lines, 1)
      `CHK(ga.size(), bw == 3 ? 0 : bw == `BW_6 ? 2 : 6)
      for (i = 0; i < ga.size() && i < 6; i++) begin
        `CHK(ga[i], st + i[16:0])
        `CHK(gd[i], pix(bw, i))
      end
      `CHK({partial_en_o, scroll_en_o}, 2'h0)
    end
    end_of_test();
  end
endmodule
`default_nettype wire
